// ==== design/cthr_consts.svh ====
// Constants of the charger threshold register bank and throttle logic
`ifndef CTHR_CONSTS_SVH
`define CTHR_CONSTS_SVH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define CTHR_CMD_FLOOR   8'h3e
`define CTHR_CMD_INOC    8'h47
`define CTHR_CMD_DISOC   8'h48
`define CTHR_CMD_CFG0    8'h39
`define CTHR_CMD_INFO    8'h3a
`define CTHR_CMD_CFG2    8'h3d

// ---------------------------------------------------------------
// Field masks, ceilings and reset values
// ---------------------------------------------------------------
`define CTHR_FLOOR_MASK  16'h3ff8
`define CTHR_FLOOR_MAX   16'h3600
`define CTHR_FLOOR_RST   16'h0000
`define CTHR_INOC_MASK   16'h1f80
`define CTHR_INOC_MAX    16'h1900
`define CTHR_INOC_RST    16'h0c00
`define CTHR_DISOC_MASK  16'h3f00
`define CTHR_DISOC_MAX   16'h3200
`define CTHR_DISOC_RST   16'h1000
`define CTHR_CFG0_MASK   16'h00ff
`define CTHR_CFG0_RST    16'h0000
`define CTHR_CFG2_RST    16'h0000
`define CTHR_WORD_ZERO   16'h0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTHR_LP_HI       4
`define CTHR_LP_LO       3
`define CTHR_DB_HI       10
`define CTHR_DB_LO       9
`define CTHR_HOLD_HI     8
`define CTHR_HOLD_LO     6
`define CTHR_INFO_REF    15

// ---------------------------------------------------------------
// Low power discharge thresholds in mA
// ---------------------------------------------------------------
`define CTHR_LP_THR0     16'h2ee0
`define CTHR_LP_THR1     16'h2710
`define CTHR_LP_THR2     16'h1f40
`define CTHR_LP_THR3     16'h1770

// ---------------------------------------------------------------
// Serial slave
// ---------------------------------------------------------------
`define CTHR_SLV_ADDR    7'h09
`define CTHR_BIT_ACK     4'h8
`define CTHR_BIT_AFTER   4'h9
`define CTHR_BIT_ONE     4'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CTHR_TW          12
`define CTHR_CLK_MHZ     100
`define CTHR_US2CYC(us)  ((us) * `CTHR_CLK_MHZ)
`define CTHR_LSV_DB_US   10
`define CTHR_DB0_US      10
`define CTHR_DB1_US      20
`define CTHR_DB2_US      30
`define CTHR_DB3_US      40
`define CTHR_HOLD0_US    1
`define CTHR_HOLD1_US    2
`define CTHR_HOLD2_US    5
`define CTHR_HOLD3_US    10
`define CTHR_HOLD4_US    15
`define CTHR_HOLD5_US    20
`define CTHR_HOLD6_US    30
`define CTHR_HOLD7_US    40

`endif

// ==== design/cthr_pkg.sv ====
// Types of the charger threshold register bank and throttle logic
`include "cthr_consts.svh"

package cthr_pkg;

  // Serial slave phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_CMD, PH_WLO, PH_WHI, PH_RLO, PH_RHI, PH_DONE
  } cthr_phase_t;

  // Throttle timer state
  typedef struct packed {
    logic [`CTHR_TW-1:0] cnt;
    logic                active;
  } cthr_timer_t;

  // Top level state
  typedef struct packed {
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_f;
    logic        sda_f;
    cthr_phase_t phase;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        nack;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [15:0] tx;
    logic        sda_oe;
    logic [15:0] floor_thr;
    logic [15:0] inoc_thr;
    logic [15:0] disoc_thr;
    logic [15:0] cfg0;
    logic [15:0] cfg2;
    logic        trickle;
    logic        learn;
    logic [15:0] target;
    logic        thr_oe;
  } cthr_state_t;

endpackage

// ==== design/cthr_throttle.sv ====
// Debounce and minimum hold timer for one throttle source
`timescale 1ns/100ps
`include "cthr_consts.svh"

module cthr_throttle
  import cthr_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Condition and timing
  input  wire logic                over,
  input  wire logic [`CTHR_TW-1:0] db_cyc,
  input  wire logic [`CTHR_TW-1:0] hold_cyc,
  // Result
  output logic                     asserted
);

  cthr_timer_t r;
  cthr_timer_t n;

  // Count consecutive over cycles, then hold for the minimum time
  always_comb begin
    n = r;
    if (!r.active) begin
      if (!over) begin
        n.cnt = '0;  // A glitch shorter than the debounce restarts it
      end else if (r.cnt + `CTHR_TW'(1) >= db_cyc) begin
        n.active = 1'b1;
        n.cnt    = '0;
      end else begin
        n.cnt = r.cnt + `CTHR_TW'(1);
      end
    end else if (r.cnt + `CTHR_TW'(1) < hold_cyc) begin
      n.cnt = r.cnt + `CTHR_TW'(1);
    end else if (!over) begin
      n.active = 1'b0;  // Released only once held long enough
      n.cnt    = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign asserted = r.active;

endmodule

// ==== design/cthr_top.sv ====
// Charger threshold registers, serial write-word slave and throttle alarm
//
// Operation
// - Write-word with command 0x3e stores the floor voltage threshold.
// - Floor writes keep field bits only and clamp at 13.824 V.
// - Floor field is bits 13:3, 8 mV per step.
// - Battery voltage against floor decides trickle and learn entry and exit.
// - In trickle mode the floor is the system regulation target.
// - Write-word with command 0x47 sets the input overcurrent threshold.
// - Input threshold keeps field bits only and clamps at 6400 mA.
// - Input threshold resets to 0x0c00 and reads back.
// - Input threshold field is bits 12:7, 128 mA per step.
// - Input overcurrent asserts throttle after debounce, holds minimum time.
// - Write-word with command 0x48 sets the discharge threshold.
// - Discharge threshold keeps field bits only and clamps at 12.8 A.
// - Discharge threshold resets to 0x1000 and reads back.
// - Discharge threshold field is bits 13:8, 256 mA per step.
// - Discharge overcurrent asserts throttle after debounce, holds minimum time.
// - Battery-only low power takes discharge threshold from config zero bits 4:3.
// - Battery-only detection needs power monitor; info bit 15 shows reference.
// - Low system voltage uses a fixed 10 us debounce.
// - Config zero bits 4:3 select 12, 10, 8 or 6 A.
`timescale 1ns/100ps
`include "cthr_consts.svh"

module cthr_top
  import cthr_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // Serial bus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // Measurements and mode inputs from the converter
  input  wire logic [15:0] INPUT_CURRENT_MA,
  input  wire logic [15:0] DISCHARGE_CURRENT_MA,
  input  wire logic [15:0] BATTERY_MV,
  input  wire logic [15:0] CEILING_VOLTAGE_SETTING,
  input  wire logic        LOW_SYSTEM_VOLTAGE,
  input  wire logic        ADAPTER_PRESENT,
  input  wire logic        LOW_POWER_MODE,
  input  wire logic        PLATFORM_POWER_MONITOR_EN,
  input  wire logic        CHARGE_REQUEST,
  input  wire logic        LEARN_REQUEST,
  // Throttle open-drain pin
  output logic             THROTTLE_N_OUT,
  output logic             THROTTLE_N_OE,
  // Mode results
  output logic             TRICKLE_ACTIVE,
  output logic             LEARN_ACTIVE,
  output logic [15:0]      VSYS_TARGET_MV
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Keep the field bits and clamp at the ceiling
  function automatic logic [15:0] clamp_word(input logic [15:0] wd,
                                             input logic [15:0] mask,
                                             input logic [15:0] top);
    logic [15:0] v;
    v = wd & mask;
    clamp_word = (v > top) ? top : v;
  endfunction

  // Debounce selection in cycles
  function automatic logic [`CTHR_TW-1:0] db_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: db_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_DB0_US));
      2'h1: db_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_DB1_US));
      2'h2: db_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_DB2_US));
      2'h3: db_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_DB3_US));
    endcase
  endfunction

  // Minimum hold selection in cycles
  function automatic logic [`CTHR_TW-1:0] hold_cycles(input logic [2:0] sel);
    unique case (sel)
      3'h0: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD0_US));
      3'h1: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD1_US));
      3'h2: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD2_US));
      3'h3: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD3_US));
      3'h4: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD4_US));
      3'h5: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD5_US));
      3'h6: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD6_US));
      3'h7: hold_cycles = `CTHR_TW'(`CTHR_US2CYC(`CTHR_HOLD7_US));
    endcase
  endfunction

  // Low power discharge threshold
  function automatic logic [15:0] lp_threshold(input logic [1:0] sel);
    unique case (sel)
      2'h0: lp_threshold = `CTHR_LP_THR0;
      2'h1: lp_threshold = `CTHR_LP_THR1;
      2'h2: lp_threshold = `CTHR_LP_THR2;
      2'h3: lp_threshold = `CTHR_LP_THR3;
    endcase
  endfunction

  // Read word for a command; unknown commands read zero
  function automatic logic [15:0] read_word(input logic [7:0]  cmd,
                                            input logic [15:0] flo,
                                            input logic [15:0] inoc,
                                            input logic [15:0] disoc,
                                            input logic [15:0] c0,
                                            input logic [15:0] c2,
                                            input logic        ref_on);
    case (cmd)
      `CTHR_CMD_FLOOR: read_word = flo;
      `CTHR_CMD_INOC:  read_word = inoc;
      `CTHR_CMD_DISOC: read_word = disoc;
      `CTHR_CMD_CFG0:  read_word = c0;
      `CTHR_CMD_CFG2:  read_word = c2;
      `CTHR_CMD_INFO:  read_word = 16'(ref_on) << `CTHR_INFO_REF;
      default:         read_word = `CTHR_WORD_ZERO;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State and throttle sources
  // ---------------------------------------------------------------
  cthr_state_t         r;
  cthr_state_t         n;
  logic [2:0]          src_over;
  logic [2:0]          src_asserted;
  logic [`CTHR_TW-1:0] src_db [3];
  logic [`CTHR_TW-1:0] hold_cyc;
  logic                ref_active;
  logic [15:0]         dis_thr;

  assign ref_active = ADAPTER_PRESENT | PLATFORM_POWER_MONITOR_EN;

  assign dis_thr = (!ADAPTER_PRESENT && LOW_POWER_MODE)
                   ? lp_threshold(r.cfg0[`CTHR_LP_HI:`CTHR_LP_LO]) : r.disoc_thr;

  assign src_over[0] = INPUT_CURRENT_MA > r.inoc_thr;
  assign src_over[1] = ref_active && (DISCHARGE_CURRENT_MA > dis_thr);
  assign src_over[2] = LOW_SYSTEM_VOLTAGE;

  // Debounce per source and the shared minimum hold
  assign src_db[0] = db_cycles(r.cfg2[`CTHR_DB_HI:`CTHR_DB_LO]);
  assign src_db[1] = db_cycles(r.cfg2[`CTHR_DB_HI:`CTHR_DB_LO]);
  assign src_db[2] = `CTHR_TW'(`CTHR_US2CYC(`CTHR_LSV_DB_US));
  assign hold_cyc  = hold_cycles(r.cfg2[`CTHR_HOLD_HI:`CTHR_HOLD_LO]);

  // One timer per source; any asserted source pulls the pin low
  generate
    for (genvar i = 0; i < 3; i++) begin : g_src
      cthr_throttle u_timer (
        .clk_sys  (CLK_SYS),
        .rstn     (RSTN),
        .over     (src_over[i]),
        .db_cyc   (src_db[i]),
        .hold_cyc (hold_cyc),
        .asserted (src_asserted[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        scl_new;
    logic        sda_new;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic [15:0] wd;
    scl_new = 1'b0;
    sda_new = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    start   = 1'b0;
    stop    = 1'b0;
    wd      = '0;
    n       = r;

    // Three-stage synchronisers; a level counts once stages two and three agree
    n.scl_sy = {r.scl_sy[1:0], SCL_IN};
    n.sda_sy = {r.sda_sy[1:0], SDA_IN};
    scl_new  = (r.scl_sy[1] == r.scl_sy[2]) ? r.scl_sy[2] : r.scl_f;
    sda_new  = (r.sda_sy[1] == r.sda_sy[2]) ? r.sda_sy[2] : r.sda_f;
    n.scl_f  = scl_new;
    n.sda_f  = sda_new;
    rise     = !r.scl_f && scl_new;
    fall     = r.scl_f && !scl_new;
    start    = r.scl_f && scl_new && r.sda_f && !sda_new;
    stop     = r.scl_f && scl_new && !r.sda_f && sda_new;
    wd       = {r.sh, r.lo};

    // Bus conditions and bit timing
    if (stop) begin
      n.phase  = PH_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.phase  = PH_ADDR;  // Repeated start keeps the command for a read
      n.cnt    = '0;
      n.sda_oe = 1'b0;
    end else if (r.phase != PH_IDLE && r.phase != PH_DONE) begin
      if (rise) begin
        if (r.cnt < `CTHR_BIT_ACK) begin
          n.sh  = {r.sh[6:0], sda_new};
          n.cnt = r.cnt + `CTHR_BIT_ONE;
        end else if (r.cnt == `CTHR_BIT_ACK) begin
          n.nack = sda_new;  // Master answer after a read byte
          n.cnt  = `CTHR_BIT_AFTER;
        end
      end else if (fall) begin
        if (r.cnt == `CTHR_BIT_ACK) begin
          // Byte complete: acknowledge or hand the slot to the master
          unique case (r.phase)
            PH_ADDR: begin
              if (r.sh[7:1] == `CTHR_SLV_ADDR) begin
                n.sda_oe = 1'b1;
                n.rw     = r.sh[0];
                n.tx = {read_word(r.cmd, r.floor_thr, r.inoc_thr, r.disoc_thr,
                                  r.cfg0, r.cfg2, ref_active)} << 0;
                n.tx = {n.tx[7:0], n.tx[15:8]};  // Low byte goes first
              end else begin
                n.phase = PH_DONE;
              end
            end
            PH_CMD: begin
              n.cmd    = r.sh;
              n.sda_oe = 1'b1;
            end
            PH_WLO: begin
              n.lo     = r.sh;
              n.sda_oe = 1'b1;
            end
            PH_WHI: begin
              n.sda_oe = 1'b1;
              // Commit on the last data byte; unknown commands are dropped
              // unused bits zero, except config two, which stores the whole word
              case (r.cmd)
                `CTHR_CMD_FLOOR: n.floor_thr = clamp_word(wd, `CTHR_FLOOR_MASK,
                                                          `CTHR_FLOOR_MAX);
                `CTHR_CMD_INOC:  n.inoc_thr  = clamp_word(wd, `CTHR_INOC_MASK,
                                                          `CTHR_INOC_MAX);
                `CTHR_CMD_DISOC: n.disoc_thr = clamp_word(wd, `CTHR_DISOC_MASK,
                                                          `CTHR_DISOC_MAX);
                `CTHR_CMD_CFG0:  n.cfg0      = wd & `CTHR_CFG0_MASK;
                `CTHR_CMD_CFG2:  n.cfg2      = wd;
                default:         n.cfg2      = r.cfg2;
              endcase
            end
            PH_RLO, PH_RHI: begin
              n.sda_oe = 1'b0;
              n.tx     = r.tx << 1;
            end
            default: n.sda_oe = 1'b0;
          endcase
        end else if (r.cnt == `CTHR_BIT_AFTER) begin
          // Leave the acknowledge slot and enter the next byte
          n.cnt    = '0;
          n.sda_oe = 1'b0;
          unique case (r.phase)
            PH_ADDR: begin
              n.phase  = r.rw ? PH_RLO : PH_CMD;
              n.sda_oe = r.rw && !r.tx[15];
            end
            PH_CMD:  n.phase = PH_WLO;
            PH_WLO:  n.phase = PH_WHI;
            PH_RLO: begin
              n.phase  = r.nack ? PH_DONE : PH_RHI;
              n.sda_oe = !r.nack && !r.tx[15];
            end
            default: n.phase = PH_DONE;
          endcase
        end else if ((r.phase == PH_RLO || r.phase == PH_RHI) && r.cnt != '0) begin
          // Next data bit, driven low only for a zero
          n.tx     = r.tx << 1;
          n.sda_oe = !r.tx[14];
        end
      end
    end

    n.trickle = CHARGE_REQUEST && (BATTERY_MV < r.floor_thr);
    n.learn   = LEARN_REQUEST && (BATTERY_MV >= r.floor_thr);
    n.target  = n.trickle ? r.floor_thr : CEILING_VOLTAGE_SETTING;
    n.thr_oe  = |src_asserted;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      r           <= '0;
      r.scl_sy    <= 3'h7;  // Idle bus is high; avoids a false start
      r.sda_sy    <= 3'h7;
      r.scl_f     <= 1'b1;
      r.sda_f     <= 1'b1;
      r.phase     <= PH_IDLE;
      r.floor_thr <= `CTHR_FLOOR_RST;
      r.inoc_thr  <= `CTHR_INOC_RST;
      r.disoc_thr <= `CTHR_DISOC_RST;
      r.cfg0      <= `CTHR_CFG0_RST;
      r.cfg2      <= `CTHR_CFG2_RST;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  // Open-drain pins only ever pull low; the enable carries the level
  assign SDA_OUT        = 1'b0 & r.sda_oe;
  assign SDA_OE         = r.sda_oe;
  assign THROTTLE_N_OUT = 1'b0 & r.thr_oe;
  assign THROTTLE_N_OE  = r.thr_oe;
  assign TRICKLE_ACTIVE = r.trickle;
  assign LEARN_ACTIVE   = r.learn;
  assign VSYS_TARGET_MV = r.target;

endmodule

// ==== sim/charger_threshold_regs_and_throttle_tb.sv ====
// Self-checking bench for the threshold bank and throttle alarm
`timescale 1ns/100ps
module charger_threshold_regs_and_throttle_tb_top;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        scl, sda, sda_oe, thr_oe, trickle, learn;
  logic [15:0] in_ma, dis_ma, bat_mv, ceil_mv, target;
  logic        lsv, adp, lpm, mon, chg, lrn;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  cthr_top cthr_top_inst (
    .CLK_SYS(clk_sys), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .INPUT_CURRENT_MA(in_ma), .DISCHARGE_CURRENT_MA(dis_ma), .BATTERY_MV(bat_mv),
    .CEILING_VOLTAGE_SETTING(ceil_mv), .LOW_SYSTEM_VOLTAGE(lsv), .ADAPTER_PRESENT(adp),
    .LOW_POWER_MODE(lpm), .PLATFORM_POWER_MONITOR_EN(mon), .CHARGE_REQUEST(chg),
    .LEARN_REQUEST(lrn), .THROTTLE_N_OUT(), .THROTTLE_N_OE(thr_oe), .TRICKLE_ACTIVE(trickle),
    .LEARN_ACTIVE(learn), .VSYS_TARGET_MV(target));
  cthr_host cthr_host_inst (.clk(clk_sys), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  always #5 clk_sys = ~clk_sys;
  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    check({15'h0000, s}, {15'h0000, e});
  endtask
  // Pin level n cycles on, once that edge's updates have landed
  task automatic oe_at(input int n, input logic e);
    repeat (n) @(posedge clk_sys);
    #1;
    chk1(thr_oe, e);
  endtask
  // Word access; acknowledge pattern checked, read data compared
  task automatic acc(input logic [7:0] cmd, input logic rd, input logic [15:0] wd,
                     input logic [15:0] exp);
    logic [15:0] q;
    logic [4:0]  n;
    // Start on an edge so the host never moves its lines between edges
    @(posedge clk_sys);
    cthr_host_inst.xfer(cmd, rd, wd, q, n);
    check({11'h000, n}, {11'h000, rd, 4'h0});
    if (rd) check(q, exp);
  endtask
  task automatic t_regs();
    logic [7:0]  cmd [6];
    logic [15:0] wd [6];
    logic [15:0] ex [6];
    cmd = '{8'h3e, 8'h47, 8'h48, 8'h3e, 8'h47, 8'h48};
    wd = '{16'hffff, 16'hffff, 16'hffff, 16'h1234, 16'h23c5, 16'hc1ff};
    ex = '{16'h3600, 16'h1900, 16'h3200, 16'h1230, 16'h0380, 16'h0100};
    acc(8'h3e, 1'b1, 16'h0000, 16'h0000);
    acc(8'h47, 1'b1, 16'h0000, 16'h0c00);
    acc(8'h48, 1'b1, 16'h0000, 16'h1000);
    acc(8'h50, 1'b1, 16'h0000, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      acc(cmd[i], 1'b0, wd[i], 16'h0000);
      acc(cmd[i], 1'b1, 16'h0000, ex[i]);
    end
  endtask
  // Floor now 0x1230; battery below, then equal to it
  task automatic t_modes();
    @(posedge clk_sys);
    chg <= 1'b1;
    bat_mv <= 16'd4000;
    oe_at(3, 1'b0);
    chk1(trickle, 1'b1);
    check(target, 16'h1230);
    @(posedge clk_sys);
    bat_mv <= 16'h1230;
    lrn <= 1'b1;
    oe_at(3, 1'b0);
    chk1(trickle, 1'b0);
    chk1(learn, 1'b1);
    check(target, ceil_mv);
    @(posedge clk_sys);
    chg <= 1'b0;
    lrn <= 1'b0;
  endtask
  // Input threshold now 896 mA; hold set to 1000 cycles
  task automatic t_input();
    acc(8'h3d, 1'b0, 16'h00c0, 16'h0000);
    @(posedge clk_sys);
    in_ma <= 16'd896;
    oe_at(1100, 1'b0);
    @(posedge clk_sys);
    in_ma <= 16'd897;
    oe_at(500, 1'b0);
    @(posedge clk_sys);
    in_ma <= 16'd0;
    oe_at(1100, 1'b0);
    @(posedge clk_sys);
    in_ma <= 16'd897;
    oe_at(999, 1'b0);
    oe_at(4, 1'b1);
    @(posedge clk_sys);
    in_ma <= 16'd0;
    oe_at(900, 1'b1);
    oe_at(200, 1'b0);
  endtask
  // Discharge threshold now 256 mA, then the low power table
  task automatic t_discharge();
    logic [15:0] lp [4];
    lp = '{16'd12000, 16'd10000, 16'd8000, 16'd6000};
    @(posedge clk_sys);
    dis_ma <= 16'd257;
    oe_at(999, 1'b0);
    oe_at(4, 1'b1);
    @(posedge clk_sys);
    dis_ma <= 16'd12001;
    adp <= 1'b0;
    lpm <= 1'b1;
    oe_at(2400, 1'b0);
    acc(8'h3a, 1'b1, 16'h0000, 16'h0000);
    @(posedge clk_sys);
    dis_ma <= 16'd0;
    mon <= 1'b1;
    acc(8'h3a, 1'b1, 16'h0000, 16'h8000);
    for (int c = 0; c < 4; c++) begin
      acc(8'h39, 1'b0, {11'h000, c[1:0], 3'h0}, 16'h0000);
      @(posedge clk_sys);
      dis_ma <= lp[c];
      oe_at(1100, 1'b0);
      @(posedge clk_sys);
      dis_ma <= lp[c] + 16'd1;
      oe_at(999, 1'b0);
      oe_at(4, 1'b1);
      @(posedge clk_sys);
      dis_ma <= 16'd0;
      oe_at(1300, 1'b0);
    end
    @(posedge clk_sys);
    adp <= 1'b1;
    lpm <= 1'b0;
  endtask
  // Longest programmable debounce must not slow the low voltage path
  task automatic t_lsv();
    acc(8'h3d, 1'b0, 16'h0600, 16'h0000);
    @(posedge clk_sys);
    lsv <= 1'b1;
    oe_at(999, 1'b0);
    oe_at(4, 1'b1);
    oe_at(20, 1'b1);
    @(posedge clk_sys);
    lsv <= 1'b0;
    oe_at(300, 1'b0);
  endtask
  initial begin
    {in_ma, dis_ma, bat_mv} = 48'h0;
    // ceiling kept above every floor value written
    ceil_mv = 16'h3840;
    {lsv, adp, lpm, mon, chg, lrn} = 6'b010000;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_regs();
    t_modes();
    t_input();
    t_discharge();
    t_lsv();
    report_and_stop();
  end
endmodule

// ==== sim/cthr_checker.sv ====
// Assertion checker for the threshold bank pins
`timescale 1ns/100ps
module cthr_checker (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  // Observed pins
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE,
  input wire logic        CHARGE_REQUEST,
  input wire logic        LEARN_REQUEST,
  input wire logic        LOW_SYSTEM_VOLTAGE,
  input wire logic [15:0] CEILING_VOLTAGE_SETTING,
  input wire logic        THROTTLE_N_OUT,
  input wire logic        THROTTLE_N_OE,
  input wire logic        TRICKLE_ACTIVE,
  input wire logic        LEARN_ACTIVE,
  input wire logic [15:0] VSYS_TARGET_MV
);
  // Fixed debounce plus pin latency with a small margin, and the shortest hold
  localparam int LSV_FIRE = 1005;
  localparam int MIN_HOLD = 100;
  logic [15:0] lsv_cnt_r;
  logic [15:0] oe_run_r;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // Run lengths; they wrap after 65535 cycles, far beyond any run here
  always_ff @(posedge CLK_SYS) begin
    lsv_cnt_r <= (RSTN && LOW_SYSTEM_VOLTAGE) ? lsv_cnt_r + 16'h0001 : 16'h0000;
    oe_run_r  <= (RSTN && THROTTLE_N_OE) ? oe_run_r + 16'h0001 : 16'h0000;
  end
  sequence lsv_held_s;
    lsv_cnt_r >= LSV_FIRE;
  endsequence
  sequence pin_release_s;
    $fell(THROTTLE_N_OE);
  endsequence
  lsv_debounce_a: assert property (lsv_held_s |-> THROTTLE_N_OE)
    else $error("throttle absent after fixed debounce");
  min_hold_a: assert property (pin_release_s |-> oe_run_r >= MIN_HOLD)
    else $error("throttle released before minimum hold");
  pin_low_a: assert property (THROTTLE_N_OE |-> !THROTTLE_N_OUT)
    else $error("throttle pin driven high");
  ack_low_a: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data line driven high");
  trickle_cause_a: assert property (!CHARGE_REQUEST |=> !TRICKLE_ACTIVE)
    else $error("trickle without charge request");
  learn_cause_a: assert property (!LEARN_REQUEST |=> !LEARN_ACTIVE)
    else $error("learn without learn request");
  mode_excl_a: assert property (!(TRICKLE_ACTIVE && LEARN_ACTIVE))
    else $error("trickle and learn together");
  target_ceil_a: assert property ($past(RSTN) && !TRICKLE_ACTIVE |->
    VSYS_TARGET_MV == $past(CEILING_VOLTAGE_SETTING))
    else $error("target differs from ceiling outside trickle");
endmodule

bind cthr_top cthr_checker cthr_checker_inst (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .CHARGE_REQUEST(CHARGE_REQUEST), .LEARN_REQUEST(LEARN_REQUEST),
  .LOW_SYSTEM_VOLTAGE(LOW_SYSTEM_VOLTAGE), .CEILING_VOLTAGE_SETTING(CEILING_VOLTAGE_SETTING),
  .THROTTLE_N_OUT(THROTTLE_N_OUT), .THROTTLE_N_OE(THROTTLE_N_OE),
  .TRICKLE_ACTIVE(TRICKLE_ACTIVE), .LEARN_ACTIVE(LEARN_ACTIVE), .VSYS_TARGET_MV(VSYS_TARGET_MV)
);

// ==== sim/cthr_host.sv ====
// Serial bus host model that writes and reads the bank by word
`timescale 1ns/100ps
`include "cthr_consts.svh"
module cthr_host (
  // Clock
  input wire logic clk,
  // Device pull-down on data
  input wire logic dev_oe,
  // Wire levels
  output logic     scl,
  output logic     sda
);
  logic drv_low_r = 1'b0;
  initial scl = 1'b1;
  // Pulled-up data line, low while either party pulls
  assign sda = !(drv_low_r || dev_oe);
  // One phase of ten clocks, well above the slave's filter lag
  task automatic ph(input logic c, input logic lo);
    scl <= c;
    drv_low_r <= lo;
    repeat (10) @(posedge clk);
  endtask
  // Data changes only while the clock is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    ph(1'b0, !b);
    ph(1'b1, !b);
    r = sda;
    ph(1'b0, !b);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
                       output logic nak);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ak, nak);
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic rd, input logic [15:0] wd,
                      output logic [15:0] q, output logic [4:0] n);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
    xbyte({`CTHR_SLV_ADDR, 1'b0}, 1'b1, q[7:0], n[0]);
    xbyte(cmd, 1'b1, q[7:0], n[1]);
    n[4] = 1'b0;
    if (rd) begin
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
      xbyte({`CTHR_SLV_ADDR, 1'b1}, 1'b1, q[7:0], n[2]);
      xbyte(8'hff, 1'b0, q[7:0], n[3]);
      xbyte(8'hff, 1'b1, q[15:8], n[4]);
    end else begin
      xbyte(wd[7:0], 1'b1, q[7:0], n[2]);
      xbyte(wd[15:8], 1'b1, q[15:8], n[3]);
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
endmodule
